// *** hw/adc_frame_pkg.sv ***
// Shared constants and types for the converter frame sequencer
package adc_frame_pkg;
   localparam int FRAME_BITS = 16;
   localparam int CNT_W = 5;
   localparam logic [CNT_W-1:0] FALL_MUX = 5'h02;
   localparam logic [CNT_W-1:0] FALL_ADDR_LAST = 5'h03;
   localparam logic [CNT_W-1:0] FALL_RES_MSB = 5'h04;
   localparam logic [CNT_W-1:0] FALL_RES_LSB = 5'h0D;
   localparam logic [CNT_W-1:0] FALL_ALARM_CLR = 5'h0A;
   localparam logic [CNT_W-1:0] FALL_ALARM_SET = 5'h0C;
   localparam logic [CNT_W-1:0] RISE_ACQ = 5'h0E;
   localparam logic [CNT_W-1:0] FALL_LAST = 5'h10;
   // Mode control word fields
   localparam int MODE_HI = 15;
   localparam int MODE_LO = 12;
   localparam int PROG_EN_BIT = 11;
   localparam int NEXT_CH_HI = 10;
   localparam int NEXT_CH_LO = 7;
   localparam int LAST_CH_HI = 9;
   localparam int LAST_CH_LO = 6;
   localparam int CNT_RESET_BIT = 10;
   localparam int RANGE_BIT = 6;
   localparam int PD_BIT = 5;
   localparam int GPIO_RD_BIT = 4;
   localparam int GPO_HI = 3;
   localparam logic [3:0] MODE_MANUAL = 4'h1;
   localparam logic [3:0] MODE_AUTO1 = 4'h2;
   localparam logic [3:0] MODE_AUTO2 = 4'h3;
   localparam logic [3:0] MODE_PROG1 = 4'h8;
   localparam logic [3:0] MODE_PROG2 = 4'h9;
   localparam logic [3:0] LAST_CH_RESET = 4'h7;
   localparam logic [6:0] CTRL_RESET = 7'h00;
   typedef enum logic [1:0] {SEQ_MANUAL, SEQ_AUTO1, SEQ_AUTO2} seq_mode_t;
endpackage

// *** hw/frame_link_if.sv ***
// Signals between the link-side shifter and the control core
`timescale 1ns/1ns
interface frame_link_if;
   // Toggles start at a known level; the serial side has no reset of its own
   logic frame_tgl = 1'b0;
   logic [15:0] rx_word = 16'h0000;
   logic [15:0] tx_word;
   logic [4:0] fall_cnt;
   logic mux_tgl = 1'b0;
   logic alarm_set_tgl = 1'b0;
   logic alarm_clr_tgl = 1'b0;
   logic pd_tgl = 1'b0;
   logic acq;
   modport link (output frame_tgl, rx_word, fall_cnt, mux_tgl,
      alarm_set_tgl, alarm_clr_tgl, pd_tgl, acq, input tx_word);
   modport core (input frame_tgl, rx_word, fall_cnt, mux_tgl,
      alarm_set_tgl, alarm_clr_tgl, pd_tgl, acq, output tx_word);
endinterface

// *** hw/serial_shifter.sv ***
// Serial-clock domain shifter: frame counting, capture and output
`timescale 1ns/1ns
module serial_shifter
   import adc_frame_pkg::*;
(
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic serial_in,
   output logic serial_out,
   output logic serial_out_oe,
   frame_link_if.link lk
);
   logic [CNT_W-1:0] rise_q;
   logic [CNT_W-1:0] fall_q;
   logic [15:0] sh_in_q;
   logic [15:0] sh_out_q;
   logic oe_q;

   // Rise counter and input capture; cleared while cs_n high
   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
         rise_q <= '0;
         sh_in_q <= '0;
         lk.acq <= 1'b0;
      end else begin
         if (rise_q < CNT_W'(FRAME_BITS)) begin
            rise_q <= rise_q + 1'b1;
            sh_in_q <= {sh_in_q[14:0], serial_in};
            if (rise_q == CNT_W'(FRAME_BITS - 1))
               lk.rx_word <= {sh_in_q[14:0], serial_in};
         end
         if (rise_q + 1'b1 == RISE_ACQ)
            lk.acq <= 1'b1;
      end
   end

   // Falling-edge counter drives output bits, MSB first
   always_ff @(negedge sclk or posedge cs_n) begin
      if (cs_n) begin
         fall_q <= '0;
         oe_q <= 1'b0;
      end else if (fall_q < FALL_LAST) begin
         fall_q <= fall_q + 1'b1;
         oe_q <= (fall_q + 1'b1) != FALL_LAST;
         // First fall loads the word; bit 15 already went out at cs_n fall
         if (fall_q == '0)
            sh_out_q <= {lk.tx_word[14:0], 1'b0};
         else
            sh_out_q <= {sh_out_q[14:0], 1'b0};
         if (fall_q + 1'b1 == FALL_MUX)
            lk.mux_tgl <= ~lk.mux_tgl;
         if (fall_q + 1'b1 == FALL_ALARM_CLR)
            lk.alarm_clr_tgl <= ~lk.alarm_clr_tgl;
         if (fall_q + 1'b1 == FALL_ALARM_SET)
            lk.alarm_set_tgl <= ~lk.alarm_set_tgl;
         if (fall_q + 1'b1 == FALL_LAST)
            lk.pd_tgl <= ~lk.pd_tgl;
      end
   end

   // Frame toggle flips at each chip-select fall, marking the frame start
   always_ff @(negedge cs_n) begin
      lk.frame_tgl <= ~lk.frame_tgl;
   end

   assign lk.fall_cnt = fall_q;
   assign serial_out = (fall_q == '0) ? lk.tx_word[15] : sh_out_q[15];
   assign serial_out_oe = !cs_n && ((fall_q == '0) || oe_q);
endmodule

// *** hw/adc_serial_frame_sequencer.sv ***
// Frame sequencer top: mode control, channel sequencing, GPIO, power-down
`timescale 1ns/1ns
// Contract
// - Each chip-select fall starts a frame, samples channel, begins conversion. Code gives no sample_now pulse for a frame starting in power-down.
// - Sixteen-bit output word, MSB first: 4-bit address, 10-bit result, two zeros.
// - Mux switches on second falling edge; acquisition from fourteenth rise.
// - General outputs updated at frame start from previous frame's data.
// - General inputs latched at frame start; sent when read-select was set.
// - First address bit at chip-select fall, rest through third falling edge.
// - Result MSB after fourth falling edge, LSB after thirteenth.
// - Sixteenth falling edge floats output and ends conversion.
// - Sixteen input bits captured on rising edges from first clock.
// - Alarm rises on twelfth falling edge, clears on tenth of next frame.
// - Power-down bit set enters power-down on sixteenth fall, next frame.
// - Power-down pin low forces power-down immediately, asynchronously.
// - Leave power-down at frame start only if bit zero and pin high.
// - Manual mode selects written channel in the following frame.
// - Auto-1 steps ascending through enabled channels, one per frame.
// - Sequence registers survive mode changes; lost on power-down or reset.
// - Auto-1 enable mask resets to all ones.
// - Auto-2 scans channel 0 to last channel then wraps; last resets 7.
// - Reset gives Manual mode, channel 0, mode code 0001.
// - Program-enable zero keeps lower seven control bits; one loads them.
// - Manual next channel is bits 10 to 7, bit 10 MSB.
// - Range bit one selects 5 V range, zero selects 2.5 V.
// - Nibble 1000 makes next frame's word the Auto-1 enable mask.
// - Nibble 1001 loads bits 9 to 6 as Auto-2 last channel.
module adc_serial_frame_sequencer
   import adc_frame_pkg::*;
#(
   parameter int NUM_CH = 8,
   parameter int RES_BITS = 10
)(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic serial_in,
   output logic serial_out,
   output logic serial_out_oe,
   input wire logic [RES_BITS-1:0] conv_result,
   input wire logic alarm_high_hit,
   input wire logic alarm_low_hit,
   input wire logic [3:0] general_pin_in,
   output logic [3:0] general_pin_out,
   output logic [3:0] general_pin_oe,
   input wire logic [3:0] pin_is_output,
   input wire logic alarm_pins_en,
   input wire logic pd_pin_en,
   output logic [3:0] mux_channel,
   output logic range_5v,
   output logic sample_now,
   output logic acquire,
   output logic power_down
);
   frame_link_if lk();

   serial_shifter u_shift (
      .sclk(sclk),
      .cs_n(cs_n),
      .serial_in(serial_in),
      .serial_out(serial_out),
      .serial_out_oe(serial_out_oe),
      .lk(lk)
   );

   // Next enabled channel above cur in the Auto-1 mask, wrapping round
   function automatic logic [3:0] next_enabled(input logic [3:0] cur,
                                               input logic [15:0] mask);
      logic [3:0] c;
      logic found;
      c = cur;
      found = 1'b0;
      for (int i = 1; i <= 16; i++) begin
         if (!found && mask[4'(cur + 4'(i))] &&
             (4'(cur + 4'(i)) < 4'(NUM_CH))) begin
            c = 4'(cur + 4'(i));
            found = 1'b1;
         end
      end
      return c;
   endfunction

   // Three-stage synchronisers for toggles and pins
   logic [2:0] fr_s, mx_s, as_s, ac_s, pd_s, aq_s, pdp_s;
   logic fr_seen_q, mx_seen_q, as_seen_q, ac_seen_q, pd_seen_q;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         fr_s <= '0;
         mx_s <= '0;
         as_s <= '0;
         ac_s <= '0;
         pd_s <= '0;
         aq_s <= '0;
         pdp_s <= 3'h7;
      end else begin
         fr_s <= {fr_s[1:0], lk.frame_tgl};
         mx_s <= {mx_s[1:0], lk.mux_tgl};
         as_s <= {as_s[1:0], lk.alarm_set_tgl};
         ac_s <= {ac_s[1:0], lk.alarm_clr_tgl};
         pd_s <= {pd_s[1:0], lk.pd_tgl};
         aq_s <= {aq_s[1:0], lk.acq};
         pdp_s <= {pdp_s[1:0], general_pin_in[3]};
      end
   end

   // Arming delay after reset
   // The serial side keeps its toggles through a reset, so a toggle left
   // high must be adopted as the idle level, not taken as a fresh event
   localparam int ARM_LEN = 4;
   logic [ARM_LEN-1:0] arm_q;
   logic armed;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n)
         arm_q <= '0;
      else
         arm_q <= {arm_q[ARM_LEN-2:0], 1'b1};
   end
   assign armed = arm_q[ARM_LEN-1];

   // Event detect once second and third stages agree on a new level
   logic ev_frame, ev_mux, ev_aset, ev_aclr, ev_pd;
   assign ev_frame = armed && (fr_s[2] == fr_s[1]) &&
                     (fr_s[2] != fr_seen_q);
   assign ev_mux = armed && (mx_s[2] == mx_s[1]) && (mx_s[2] != mx_seen_q);
   assign ev_aset = armed && (as_s[2] == as_s[1]) &&
                    (as_s[2] != as_seen_q);
   assign ev_aclr = armed && (ac_s[2] == ac_s[1]) &&
                    (ac_s[2] != ac_seen_q);
   assign ev_pd = armed && (pd_s[2] == pd_s[1]) && (pd_s[2] != pd_seen_q);

   // Seen levels follow the synchronisers while not yet armed
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         fr_seen_q <= 1'b0;
         mx_seen_q <= 1'b0;
         as_seen_q <= 1'b0;
         ac_seen_q <= 1'b0;
         pd_seen_q <= 1'b0;
      end else if (!armed) begin
         fr_seen_q <= fr_s[2];
         mx_seen_q <= mx_s[2];
         as_seen_q <= as_s[2];
         ac_seen_q <= ac_s[2];
         pd_seen_q <= pd_s[2];
      end else begin
         if (ev_frame) fr_seen_q <= fr_s[2];
         if (ev_mux) mx_seen_q <= mx_s[2];
         if (ev_aset) as_seen_q <= as_s[2];
         if (ev_aclr) ac_seen_q <= ac_s[2];
         if (ev_pd) pd_seen_q <= pd_s[2];
      end
   end

   // Level inputs, power-down pin is active low
   logic pd_pin_low;
   assign pd_pin_low = pd_pin_en && !pdp_s[2] && !pdp_s[1];
   assign acquire = aq_s[2] && aq_s[1];

   // Control state
   seq_mode_t mode_q;
   logic [6:0] ctrl_q;
   logic [15:0] auto1_mask_q;
   logic [3:0] last_ch_q;
   logic [3:0] cur_ch_q;
   logic [3:0] next_ch_q;
   logic prog1_pend_q;
   logic reset_cnt_q;
   logic [3:0] gpi_q;
   logic range_q;
   logic pd_bit_q;
   logic pd_q;
   logic [3:0] gpo_q;
   logic alarm_hi_q, alarm_lo_q;
   logic [15:0] rx;
   logic [3:0] nib;
   assign rx = lk.rx_word;
   assign nib = rx[MODE_HI:MODE_LO];

   // Decode the word once the frame's last fall is seen
   // Decoding at the end rather than at the next start leaves the whole
   // idle gap for the word to settle before the next frame's first bits
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         mode_q <= SEQ_MANUAL;
         ctrl_q <= CTRL_RESET;
         auto1_mask_q <= '1;
         last_ch_q <= LAST_CH_RESET;
         next_ch_q <= '0;
         prog1_pend_q <= 1'b0;
         reset_cnt_q <= 1'b0;
      end else begin
         // Power-down drops the programs, but words are still decoded
         // so that a cleared power-down bit can bring the part back
         if (pd_q) begin
            auto1_mask_q <= '1;
            last_ch_q <= LAST_CH_RESET;
            prog1_pend_q <= 1'b0;
         end
         if (ev_pd) begin
            reset_cnt_q <= 1'b0;
            if (prog1_pend_q) begin
               auto1_mask_q <= rx;
               prog1_pend_q <= 1'b0;
            end else if (nib == MODE_PROG1) begin
               prog1_pend_q <= 1'b1;
            end else if (nib == MODE_PROG2) begin
               last_ch_q <= rx[LAST_CH_HI:LAST_CH_LO];
            end else if (nib == MODE_MANUAL || nib == MODE_AUTO1 ||
                         nib == MODE_AUTO2) begin
               mode_q <= (nib == MODE_MANUAL) ? SEQ_MANUAL :
                         (nib == MODE_AUTO1) ? SEQ_AUTO1 : SEQ_AUTO2;
               if (nib == MODE_MANUAL)
                  next_ch_q <= rx[NEXT_CH_HI:NEXT_CH_LO];
               if (rx[PROG_EN_BIT]) begin
                  ctrl_q <= rx[6:0];
                  if (nib != MODE_MANUAL)
                     reset_cnt_q <= rx[CNT_RESET_BIT];
               end
            end
         end
      end
   end

   // Channel advance on the second falling edge
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cur_ch_q <= '0;
      end else if (ev_mux) begin
         case (mode_q)
            SEQ_MANUAL: cur_ch_q <= next_ch_q;
            SEQ_AUTO1: begin
               if (reset_cnt_q)
                  cur_ch_q <= next_enabled(4'hF, auto1_mask_q);
               else
                  cur_ch_q <= next_enabled(cur_ch_q, auto1_mask_q);
            end
            SEQ_AUTO2: begin
               if (reset_cnt_q || cur_ch_q >= last_ch_q)
                  cur_ch_q <= '0;
               else
                  cur_ch_q <= cur_ch_q + 4'h1;
            end
            default: cur_ch_q <= '0;
         endcase
      end
   end
   assign mux_channel = cur_ch_q;
   assign range_5v = range_q;

   // Pin image for the status read, three stages from the pins
   // The image freezes once the frame start is seen; the shifter takes it
   // on the first serial fall, so it must not move inside a frame
   logic [3:0] gp1_q, gp2_q, gp3_q;
   logic frame_busy_q;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         gp1_q <= '0;
         gp2_q <= '0;
         gp3_q <= '0;
         gpi_q <= '0;
         frame_busy_q <= 1'b0;
         range_q <= 1'b0;
         sample_now <= 1'b0;
      end else begin
         gp1_q <= general_pin_in;
         gp2_q <= gp1_q;
         gp3_q <= gp2_q;
         sample_now <= ev_frame && !pd_q;
         if (!frame_busy_q && gp2_q == gp3_q)
            gpi_q <= gp3_q;
         if (ev_frame) begin
            frame_busy_q <= 1'b1;
            range_q <= ctrl_q[RANGE_BIT];
         end else if (ev_pd) begin
            frame_busy_q <= 1'b0;
         end
      end
   end

   // Output word: address or pin status, then left-justified result
   // The channel register only moves after the second fall, so it still
   // names the sampled channel when the first fall loads the word
   assign lk.tx_word = {(ctrl_q[GPIO_RD_BIT] ? gpi_q : cur_ch_q),
                        conv_result,
                        {(12 - RES_BITS){1'b0}}};

   // General outputs refresh at frame start
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n)
         gpo_q <= '0;
      else if (ev_frame)
         gpo_q <= ctrl_q[GPO_HI:0];
   end

   // Alarms, set wins over a clear arriving together
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         alarm_hi_q <= 1'b0;
         alarm_lo_q <= 1'b0;
      end else if (ev_aset) begin
         alarm_hi_q <= alarm_high_hit;
         alarm_lo_q <= alarm_low_hit;
      end else if (ev_aclr) begin
         alarm_hi_q <= 1'b0;
         alarm_lo_q <= 1'b0;
      end
   end

   always_comb begin
      general_pin_out = gpo_q;
      general_pin_oe = pin_is_output;
      if (alarm_pins_en) begin
         general_pin_out[1:0] = {alarm_lo_q, alarm_hi_q};
         general_pin_oe[1:0] = 2'b11;
      end
      if (pd_pin_en)
         general_pin_oe[3] = 1'b0;
   end

   // Power-down: bit acts at the 16th fall of the next frame
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         pd_bit_q <= 1'b0;
         pd_q <= 1'b0;
      end else begin
         if (ev_frame)
            pd_bit_q <= ctrl_q[PD_BIT];
         if (pd_pin_low)
            pd_q <= 1'b1;
         else if (ev_pd && pd_bit_q)
            pd_q <= 1'b1;
         else if (ev_frame && !ctrl_q[PD_BIT])
            pd_q <= 1'b0;
      end
   end
   // Pin low forces power-down without waiting for any clock
   assign power_down = pd_q || (pd_pin_en && !general_pin_in[3]);
endmodule

// *** tb/adc_frame_monitor.sv ***
// Port-level assertions for the frame sequencer
`timescale 1ns/1ns
module adc_frame_monitor (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic cs_n,
   input wire logic serial_out_oe,
   input wire logic [3:0] general_pin_in,
   input wire logic pd_pin_en,
   input wire logic range_5v,
   input wire logic sample_now,
   input wire logic acquire,
   input wire logic power_down
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   // Frame start and idle gap as seen from the system clock
   sequence frame_start;
      $fell(cs_n) && !power_down;
   endsequence
   sequence cs_quiet;
      cs_n [*2];
   endsequence
   // Output enable follows the frame
   chk_oe_idle: assert property (cs_quiet |-> !serial_out_oe)
      else $error("serial output driven between frames");
   chk_oe_start: assert property ($fell(cs_n) |-> serial_out_oe)
      else $error("serial output not driven at frame start");
   // One sample pulse per frame started out of power-down, soon after its start
   chk_sample_due: assert property (frame_start |-> ##[1:5] sample_now)
      else $error("no sample pulse after frame start");
   chk_sample_one: assert property (sample_now |=> !sample_now)
      else $error("sample pulse too long");
   // Acquisition only late in a frame, gone once it ends
   chk_acq_early: assert property ($fell(cs_n) |-> ##1 !acquire [*8])
      else $error("acquisition early in frame");
   chk_acq_rise: assert property ($rose(acquire) |-> !cs_n)
      else $error("acquisition started outside a frame");
   chk_acq_end: assert property ($rose(cs_n) |-> ##4 !acquire)
      else $error("acquisition outlived its frame");
   // Power-down entry by pin and exit only at frame start
   chk_pd_pin: assert property (pd_pin_en && !general_pin_in[3] |-> power_down)
      else $error("power-down pin ignored");
   chk_pd_hold: assert property ($past(power_down) && cs_n && $past(cs_n)
      |-> power_down)
      else $error("power-down left between frames");
   // Range only moves while a frame is running
   chk_range_hold: assert property (!$stable(range_5v) |-> !cs_n)
      else $error("range changed between frames");
endmodule

bind adc_serial_frame_sequencer adc_frame_monitor i_mon (
   .mclk(mclk), .reset_n(reset_n), .cs_n(cs_n),
   .serial_out_oe(serial_out_oe), .general_pin_in(general_pin_in),
   .pd_pin_en(pd_pin_en), .range_5v(range_5v), .sample_now(sample_now),
   .acquire(acquire), .power_down(power_down));

// *** tb/serial_host_model.sv ***
// Behavioural host running one sixteen-clock frame per start pulse
`timescale 1ns/1ns
module serial_host_model (
   input wire logic start,
   input wire logic [15:0] word_in,
   input wire logic serial_out,
   input wire logic serial_out_oe,
   output logic cs_n,
   output logic sclk,
   output logic serial_in,
   output logic [15:0] word_out,
   output logic float_seen,
   output logic busy
);
   // Idle: select high, clock parked low
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      serial_in = 1'b0;
      busy = 1'b0;
   end
   // 160 ns clock only inside a frame; data set on the falling side
   always @(posedge start) begin
      busy = 1'b1;
      cs_n = 1'b0;
      for (int k = 15; k >= 0; k--) begin
         serial_in = word_in[k];
         #80 sclk = 1'b1;
         word_out[k] = serial_out_oe ? serial_out : 1'bx;
         #80 sclk = 1'b0;
      end
      #20 float_seen = !serial_out_oe;
      #60 cs_n = 1'b1;
      // Released line must not look like stale data
      serial_in = !serial_in;
      #300 busy = 1'b0;
   end
endmodule

// *** tb/adc_serial_frame_sequencer_tb.sv ***
// Self-checking bench for the converter frame sequencer
`timescale 1ns/1ns
module adc_serial_frame_sequencer_tb;
   import adc_frame_pkg::*;
   typedef struct {
      logic [15:0] word;
      logic [9:0] conv;
      logic [3:0] top;
      logic [3:0] mux;
      logic rng;
      logic [3:0] general_output;
   } row_t;
   row_t rows [7];
   logic mclk, reset_n, start, cs_n, sclk, serial_in;
   logic serial_out, serial_out_oe, float_seen, busy;
   logic [15:0] tx_word, rx_word;
   logic [9:0] conv;
   logic hi_hit, lo_hit, al_en, pd_en, rng, smp, acq, pd;
   logic [3:0] ext_lvl, pin_out, pin_oe, pins_in, mux;
   int n_mismatch, n_tests;

   // Pin level from whoever drives it
   assign pins_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);

   adc_serial_frame_sequencer i_dut (
      .mclk(mclk), .reset_n(reset_n), .cs_n(cs_n), .sclk(sclk),
      .serial_in(serial_in), .serial_out(serial_out),
      .serial_out_oe(serial_out_oe), .conv_result(conv),
      .alarm_high_hit(hi_hit), .alarm_low_hit(lo_hit),
      .general_pin_in(pins_in), .general_pin_out(pin_out),
      .general_pin_oe(pin_oe), .pin_is_output(4'h3),
      .alarm_pins_en(al_en), .pd_pin_en(pd_en), .mux_channel(mux),
      .range_5v(rng), .sample_now(smp), .acquire(acq), .power_down(pd));

   serial_host_model i_host (
      .start(start), .word_in(tx_word), .serial_out(serial_out),
      .serial_out_oe(serial_out_oe), .cs_n(cs_n), .sclk(sclk),
      .serial_in(serial_in), .word_out(rx_word),
      .float_seen(float_seen), .busy(busy));

   // 20 MHz system clock
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   task automatic check(input string what, input logic [15:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // One host frame; a hung frame ends the run
   task automatic frame(input logic [15:0] w);
      int k;
      k = 0;
      tx_word = w;
      start = 1'b1;
      @(negedge mclk);
      start = 1'b0;
      while (busy !== 1'b0 && k < 200) begin
         @(negedge mclk);
         k++;
      end
      if (k == 200) begin
         n_mismatch++;
         tally_and_finish();
      end
   endtask

   // Reset ten cycles, then the power-on defaults
   task automatic do_reset();
      reset_n = 1'b0;
      repeat (10) @(negedge mclk);
      reset_n = 1'b1;
      @(negedge mclk);
      check("channel", mux, 4'h0);
      check("range", rng, 1'b0);
      check("power", pd, 1'b0);
      check("gpo", pin_out, 4'h0);
   endtask

   // Next enabled channel above c, wrapping at eight
   function automatic logic [3:0] nxt(input logic [7:0] m,
      input logic [3:0] c);
      logic [3:0] n;
      n = c;
      for (int i = 0; i < 8; i++) begin
         n = (n + 4'h1) & 4'h7;
         if (m[n[2:0]]) return n;
      end
      return c;
   endfunction

   // Settle, anchor on the scan, then follow it; phase is left open
   task automatic run_auto(input logic [15:0] w, input logic [7:0] m);
      logic [3:0] ch;
      frame(w);
      frame(w);
      ch = mux;
      check("scan on", m[ch], 1'b1);
      repeat (4) begin
         frame(w);
         ch = nxt(m, ch);
         check("scan", mux, ch);
      end
   endtask

   initial begin
      n_mismatch = 0;
      n_tests = 0;
      reset_n = 1'b0;
      start = 1'b0;
      tx_word = 16'h0000;
      conv = 10'h000;
      hi_hit = 1'b0;
      lo_hit = 1'b0;
      al_en = 1'b0;
      pd_en = 1'b0;
      ext_lvl = 4'hC;
      rows[0] = '{16'h1981, 10'h3FF, 4'h0, 4'h0, 1'b0, 4'h0};
      rows[1] = '{16'h1AD1, 10'h001, 4'h0, 4'h3, 1'b0, 4'h1};
      rows[2] = '{16'h1B83, 10'h2AA, 4'hD, 4'h5, 1'b1, 4'h1};
      rows[3] = '{16'h1942, 10'h155, 4'h5, 4'h7, 1'b0, 4'h3};
      rows[4] = '{16'h1100, 10'h200, 4'h7, 4'h2, 1'b1, 4'h2};
      rows[5] = '{16'h1800, 10'h0F0, 4'h2, 4'h2, 1'b1, 4'h2};
      rows[6] = '{16'h1800, 10'h30F, 4'h2, 4'h0, 1'b0, 4'h0};
      do_reset();
      foreach (rows[i]) begin
         conv = rows[i].conv;
         frame(rows[i].word);
         check("word", rx_word, {rows[i].top, rows[i].conv, 2'b00});
         check("float", float_seen, 1'b1);
         check("channel", mux, rows[i].mux);
         check("range", rng, rows[i].rng);
         check("gpo", pin_out & 4'h3, rows[i].general_output);
      end
      // Program both scans, then revisit the first untouched
      frame(16'h8000);
      frame(16'h00A4);
      run_auto(16'h2000, 8'hA4);
      frame(16'h9080);
      run_auto(16'h3000, 8'h07);
      run_auto(16'h2000, 8'hA4);
      do_reset();
      run_auto(16'h2000, 8'hFF);
      run_auto(16'h3000, 8'hFF);
      // Alarms raised in one frame, cleared in the next
      al_en = 1'b1;
      hi_hit = 1'b1;
      lo_hit = 1'b1;
      frame(16'h1800);
      check("alarm", pin_out & 4'h3, 4'h3);
      hi_hit = 1'b0;
      lo_hit = 1'b0;
      frame(16'h1800);
      check("alarm", pin_out & 4'h3, 4'h0);
      al_en = 1'b0;
      // Power-down bit takes effect one frame late
      frame(16'h1820);
      check("power", pd, 1'b0);
      frame(16'h1800);
      check("power", pd, 1'b1);
      frame(16'h1800);
      frame(16'h1800);
      check("power", pd, 1'b0);
      // Pin power-down is immediate, exit waits for a frame
      pd_en = 1'b1;
      ext_lvl = 4'h4;
      @(negedge mclk);
      check("power", pd, 1'b1);
      repeat (4) @(negedge mclk);
      ext_lvl = 4'hC;
      repeat (4) @(negedge mclk);
      check("power", pd, 1'b1);
      frame(16'h1800);
      frame(16'h1800);
      check("power", pd, 1'b0);
      tally_and_finish();
   end
endmodule
